// ==== rtl/cfs_feed_seq.sv ====
// Chipper feed sequencer: forward and reverse drive outputs, auto and override.
// Assumes speed and keys are synchronous to clk_i; AXI4-Lite registers.
module cfs_feed_seq #(
  parameter int unsigned HOLD_CYC = cfs_pkg::HOLD_CYC,
  parameter int unsigned MS_CYC = cfs_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [15:0] speed_i,
  input wire logic engine_run_i,
  input wire logic password_ok_i,
  input wire logic key_enter_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_back_i,
  input wire logic key_menu_i,
  output logic fwd_drive_o,
  output logic rev_drive_o,
  output logic [2:0] ui_state_o,
  output logic overspeed_override_warning_o
);
  typedef struct packed {
    logic aw_ok;
    logic [7:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] ctrl;
    logic [15:0] fwd_thr;
    logic [15:0] rev_thr;
    logic [15:0] pulse_ms;
    cfs_pkg::cfs_ui_t ui;
    cfs_pkg::cfs_feed_t feed;
    logic [15:0] ms_left;
    logic [cfs_pkg::MS_W-1:0] ms_div;
    logic warn;
    logic up_lead;
    logic dn_lead;
    cfs_pkg::cfs_key_t code;
    logic fwd;
    logic rev;
  } cfs_state_t;

  cfs_state_t s_q;
  cfs_state_t s_d;
  cfs_hold_if hold ();

  function automatic logic [15:0] cfs_merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] ws
  );
    logic [15:0] r;
    r = old;
    if (ws[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (ws[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : cfs_merge16

  cfs_hold_timer #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hold(hold)
  );

  assign hold.code = s_q.code;

  logic man;
  logic ovl;
  logic in_ovr;
  logic warn_set;
  logic warn_clr;
  logic [31:0] rd;
  logic rd_ok;

  assign man = s_q.ctrl[cfs_pkg::CTRL_MAN_BIT];
  assign ovl = s_q.ctrl[cfs_pkg::CTRL_OVL_BIT];
  assign in_ovr = s_q.ui == cfs_pkg::UI_OVR_OFF || s_q.ui == cfs_pkg::UI_OVR_FWD
                  || s_q.ui == cfs_pkg::UI_OVR_REV;

  // Read data mux
  always_comb
  begin
    rd = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      cfs_pkg::OFS_CTRL: rd[1:0] = s_q.ctrl;
      cfs_pkg::OFS_FWD: rd[15:0] = s_q.fwd_thr;
      cfs_pkg::OFS_REV: rd[15:0] = s_q.rev_thr;
      cfs_pkg::OFS_PULSE: rd[15:0] = s_q.pulse_ms;
      cfs_pkg::OFS_SPEED: rd[15:0] = speed_i;
      cfs_pkg::OFS_STAT:
      begin
        rd[cfs_pkg::STAT_FWD_BIT] = s_q.fwd;
        rd[cfs_pkg::STAT_REV_BIT] = s_q.rev;
        rd[cfs_pkg::STAT_WARN_BIT] = s_q.warn;
        rd[cfs_pkg::STAT_UI_LSB +: 3] = s_q.ui;
        rd[cfs_pkg::STAT_FEED_LSB +: 2] = s_q.feed;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    warn_set = 1'b0;
    warn_clr = 1'b0;

    // Write address and data are caught independently, in either order
    if (!s_q.aw_ok && s_axi_awvalid_i)
    begin
      s_d.aw_ok = 1'b1;
      s_d.aw_a = s_axi_awaddr_i;
    end
    if (!s_q.w_ok && s_axi_wvalid_i)
    begin
      s_d.w_ok = 1'b1;
      s_d.w_d = s_axi_wdata_i;
      s_d.w_s = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid)
    begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = cfs_pkg::RESP_OK;
      unique case (s_q.aw_a)
        cfs_pkg::OFS_CTRL:
        begin
          if (s_q.w_s[0])
          begin
            s_d.ctrl = s_q.w_d[1:0];
          end
        end
        cfs_pkg::OFS_FWD: s_d.fwd_thr = cfs_merge16(s_q.fwd_thr, s_q.w_d, s_q.w_s);
        cfs_pkg::OFS_REV: s_d.rev_thr = cfs_merge16(s_q.rev_thr, s_q.w_d, s_q.w_s);
        cfs_pkg::OFS_PULSE: s_d.pulse_ms = cfs_merge16(s_q.pulse_ms, s_q.w_d, s_q.w_s);
        cfs_pkg::OFS_STAT:
        begin
          warn_clr = s_q.w_s[0] && s_q.w_d[cfs_pkg::STAT_WARN_BIT];
        end
        cfs_pkg::OFS_SPEED: s_d.bresp = cfs_pkg::RESP_OK;
        default: s_d.bresp = cfs_pkg::RESP_ERR;
      endcase
    end

    // Read channel: one outstanding read
    if (s_q.rvalid && s_axi_rready_i)
    begin
      s_d.rvalid = 1'b0;
    end
    if (!s_q.rvalid && s_axi_arvalid_i)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rd_ok ? cfs_pkg::RESP_OK : cfs_pkg::RESP_ERR;
    end

    // Key order tracking: the arrow must be down before Enter
    if (!key_up_i)
    begin
      s_d.up_lead = 1'b0;
    end
    else if (!key_enter_i)
    begin
      s_d.up_lead = 1'b1;
    end
    if (!key_down_i)
    begin
      s_d.dn_lead = 1'b0;
    end
    else if (!key_enter_i)
    begin
      s_d.dn_lead = 1'b1;
    end
    s_d.code = cfs_pkg::K_NONE;
    if (key_back_i && !key_enter_i && !key_up_i && !key_down_i)
    begin
      s_d.code = cfs_pkg::K_BACK;
    end
    else if (key_enter_i && key_up_i && s_q.up_lead && !key_down_i && !key_back_i)
    begin
      s_d.code = cfs_pkg::K_FWD;
    end
    else if (key_enter_i && key_down_i && s_q.dn_lead && !key_up_i && !key_back_i)
    begin
      s_d.code = cfs_pkg::K_REV;
    end
    else if (key_enter_i && !key_up_i && !key_down_i && !key_back_i)
    begin
      s_d.code = cfs_pkg::K_ENTER;
    end

    // Operator menu
    unique case (s_q.ui)
      cfs_pkg::UI_FRONT:
      begin
        if (password_ok_i)
        begin
          s_d.ui = cfs_pkg::UI_MAIN;
        end
      end
      cfs_pkg::UI_MAIN:
      begin
        if (key_menu_i)
        begin
          s_d.ui = cfs_pkg::UI_FRONT;
          warn_clr = 1'b1;
        end
        else if (hold.fire && s_q.code == cfs_pkg::K_ENTER)
        begin
          if (man && speed_i < s_q.rev_thr)
          begin
            s_d.ui = cfs_pkg::UI_OVR_OFF;
            warn_clr = 1'b1;
          end
          else
          begin
            warn_set = 1'b1;
          end
        end
      end
      default:
      begin
        if (!man)
        begin
          s_d.ui = cfs_pkg::UI_MAIN;
        end
        else if (hold.fire)
        begin
          unique case (s_q.code)
            cfs_pkg::K_BACK: s_d.ui = cfs_pkg::UI_MAIN;
            cfs_pkg::K_ENTER: s_d.ui = cfs_pkg::UI_OVR_OFF;
            cfs_pkg::K_FWD: s_d.ui = cfs_pkg::UI_OVR_FWD;
            cfs_pkg::K_REV: s_d.ui = cfs_pkg::UI_OVR_REV;
            default: s_d.ui = s_q.ui;
          endcase
        end
      end
    endcase

    // Set wins over a clear in the same cycle
    if (warn_set)
    begin
      s_d.warn = 1'b1;
    end
    else if (warn_clr)
    begin
      s_d.warn = 1'b0;
    end

    // Automatic feed; restarts from off whenever it is not in charge
    if (!man || !engine_run_i || in_ovr)
    begin
      s_d.feed = cfs_pkg::FD_OFF;
    end
    else
    begin
      unique case (s_q.feed)
        cfs_pkg::FD_OFF, cfs_pkg::FD_DONE:
        begin
          if (speed_i >= s_q.fwd_thr)
          begin
            s_d.feed = cfs_pkg::FD_FWD;
          end
        end
        cfs_pkg::FD_FWD:
        begin
          if (speed_i <= s_q.rev_thr)
          begin
            s_d.feed = cfs_pkg::FD_REV;
            s_d.ms_left = s_q.pulse_ms;
            s_d.ms_div = '0;
          end
        end
        cfs_pkg::FD_REV:
        begin
          if (s_q.ms_left == '0)
          begin
            s_d.feed = cfs_pkg::FD_DONE;
          end
          else if (s_q.ms_div == cfs_pkg::MS_W'(MS_CYC - 1))
          begin
            s_d.ms_div = '0;
            s_d.ms_left = s_q.ms_left - 1'b1;
          end
          else
          begin
            s_d.ms_div = s_q.ms_div + 1'b1;
          end
        end
      endcase
    end

    // Drive outputs follow the next state so they change with it
    s_d.fwd = 1'b0;
    s_d.rev = 1'b0;
    unique case (s_d.ui)
      cfs_pkg::UI_OVR_FWD: s_d.fwd = 1'b1;
      cfs_pkg::UI_OVR_REV:
      begin
        s_d.fwd = ovl;
        s_d.rev = 1'b1;
      end
      cfs_pkg::UI_OVR_OFF: s_d.fwd = 1'b0;
      default:
      begin
        if (s_d.feed == cfs_pkg::FD_FWD)
        begin
          s_d.fwd = 1'b1;
        end
        else if (s_d.feed == cfs_pkg::FD_REV)
        begin
          s_d.fwd = ovl;
          s_d.rev = 1'b1;
        end
      end
    endcase
  end

  // Exclusive style and manual mode set after reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '{aw_ok: 1'b0, aw_a: '0, w_ok: 1'b0, w_d: '0, w_s: '0,
               bvalid: 1'b0, bresp: cfs_pkg::RESP_OK, rvalid: 1'b0, rdata: '0,
               rresp: cfs_pkg::RESP_OK, ctrl: cfs_pkg::CTRL_RST,
               fwd_thr: cfs_pkg::FWD_RST, rev_thr: cfs_pkg::REV_RST,
               pulse_ms: cfs_pkg::PULSE_RST, ui: cfs_pkg::UI_FRONT,
               feed: cfs_pkg::FD_OFF, ms_left: '0, ms_div: '0, warn: 1'b0,
               up_lead: 1'b0, dn_lead: 1'b0, code: cfs_pkg::K_NONE,
               fwd: 1'b0, rev: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = !s_q.aw_ok;
  assign s_axi_wready_o = !s_q.w_ok;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_arready_o = !s_q.rvalid;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign fwd_drive_o = s_q.fwd;
  assign rev_drive_o = s_q.rev;
  assign ui_state_o = s_q.ui;
  assign overspeed_override_warning_o = s_q.warn;
endmodule : cfs_feed_seq

// ==== rtl/cfs_hold_if.sv ====
// Carrier between the sequencer and its key-hold timer.
// Assumes both ends run on the same clock.
interface cfs_hold_if;
  cfs_pkg::cfs_key_t code;
  logic fire;
  modport timer (input code, output fire);
  modport user (output code, input fire);
endinterface : cfs_hold_if

// ==== rtl/cfs_hold_timer.sv ====
// Key-hold timer: pulses fire once when one key gesture is held unbroken.
// Assumes code is registered logic in the same clock domain.
module cfs_hold_timer #(
  parameter int unsigned HOLD_CYC = cfs_pkg::HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  cfs_hold_if.timer hold
);
  typedef struct packed {
    logic [cfs_pkg::HOLD_W-1:0] cnt;
    cfs_pkg::cfs_key_t last;
    logic done;
    logic fire;
  } cfs_hold_st_t;

  cfs_hold_st_t s_q;
  cfs_hold_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.fire = 1'b0;
    s_d.last = hold.code;
    // Any change of the held keys restarts the count
    if (hold.code != s_q.last || hold.code == cfs_pkg::K_NONE)
    begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end
    else if (!s_q.done)
    begin
      if (s_q.cnt == cfs_pkg::HOLD_W'(HOLD_CYC - 1))
      begin
        s_d.fire = 1'b1;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '{cnt: '0, last: cfs_pkg::K_NONE, done: 1'b0, fire: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hold.fire = s_q.fire;
endmodule : cfs_hold_timer

// ==== rtl/cfs_pkg.sv ====
// Shared constants and types of the chipper feed sequencer.
// Assumes a 50 MHz system clock and an AXI4-Lite register master.
package cfs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned HOLD_S = 5;
  localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
  localparam int HOLD_W = 28;
  localparam int MS_W = 16;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FWD = 8'h04;
  localparam logic [7:0] OFS_REV = 8'h08;
  localparam logic [7:0] OFS_PULSE = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_SPEED = 8'h14;

  localparam int CTRL_MAN_BIT = 0;
  localparam int CTRL_OVL_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] FWD_RST = 16'h0898;
  localparam logic [15:0] REV_RST = 16'h0708;
  localparam logic [15:0] PULSE_RST = 16'h0032;

  localparam int STAT_FWD_BIT = 0;
  localparam int STAT_REV_BIT = 1;
  localparam int STAT_WARN_BIT = 2;
  localparam int STAT_UI_LSB = 4;
  localparam int STAT_FEED_LSB = 8;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {UI_FRONT, UI_MAIN, UI_OVR_OFF, UI_OVR_FWD, UI_OVR_REV} cfs_ui_t;
  typedef enum logic [1:0] {FD_OFF, FD_FWD, FD_REV, FD_DONE} cfs_feed_t;
  typedef enum logic [2:0] {K_NONE, K_ENTER, K_FWD, K_REV, K_BACK} cfs_key_t;
endpackage : cfs_pkg

// ==== verif/cfs_feed_seq_asserts.sv ====
// Port-level checker of the chipper feed sequencer.
// Assumes it is bound into cfs_feed_seq; one clock domain.
module cfs_feed_seq_asserts #(
  parameter int unsigned HOLD_CYC = cfs_pkg::HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic engine_run_i,
  input wire logic password_ok_i,
  input wire logic key_enter_i,
  input wire logic key_menu_i,
  input wire logic fwd_drive_o,
  input wire logic rev_drive_o,
  input wire logic [2:0] ui_state_o,
  input wire logic overspeed_override_warning_o
);
  logic [31:0] enter_cnt_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Saturates so that long holds never wrap
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      enter_cnt_q <= '0;
    else if (!key_enter_i)
      enter_cnt_q <= '0;
    else if (enter_cnt_q < HOLD_CYC)
      enter_cnt_q <= enter_cnt_q + 32'h1;
  end
  sequence s_enter_ovr;
    ui_state_o == 3'h1 ##1 ui_state_o == 3'h2;
  endsequence
  sequence s_leave_front;
    ui_state_o == 3'h0 ##1 ui_state_o == 3'h1;
  endsequence
  a_stopped_drives_off: assert property ((!engine_run_i && ui_state_o < 3'h2) [*2]
    |-> !fwd_drive_o && !rev_drive_o) else $error("drive on, engine stopped");
  a_fwd_ovr_drive: assert property (ui_state_o == 3'h3
    |-> fwd_drive_o && !rev_drive_o) else $error("forward state drives wrong");
  a_rev_ovr_drive: assert property (ui_state_o == 3'h4 |-> rev_drive_o)
    else $error("reverse state without reverse drive");
  a_idle_ovr_drive: assert property (ui_state_o == 3'h2
    |-> !fwd_drive_o && !rev_drive_o) else $error("idle state with drive on");
  a_main_needs_pass: assert property (s_leave_front |-> $past(password_ok_i)
    || $past(password_ok_i, 2)) else $error("main menu without password");
  a_ovr_from_main: assert property (ui_state_o >= 3'h2 && $past(ui_state_o) < 3'h2
    |-> $past(ui_state_o) == 3'h1) else $error("override entered off main");
  a_enter_hold_len: assert property (s_enter_ovr |-> enter_cnt_q >= HOLD_CYC)
    else $error("override entered on short hold");
  a_warn_stays_main: assert property ($rose(overspeed_override_warning_o)
    |-> ui_state_o == 3'h1) else $error("warning outside main menu");
  a_menu_to_front: assert property (ui_state_o == 3'h1 && key_menu_i
    |=> ui_state_o == 3'h0) else $error("menu key ignored");
endmodule : cfs_feed_seq_asserts

bind cfs_feed_seq cfs_feed_seq_asserts #(.HOLD_CYC(HOLD_CYC)) u_asserts (.clk_i, .rst_i,
  .engine_run_i, .password_ok_i, .key_enter_i, .key_menu_i, .fwd_drive_o, .rev_drive_o,
  .ui_state_o, .overspeed_override_warning_o);

// ==== verif/cfs_feed_seq_bench.sv ====
// Self-checking bench of the feed sequencer: AXI4-Lite master and operator model.
// Assumes short hold and millisecond counts set through parameters.
module cfs_feed_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 20;
  logic clk_i;
  logic rst_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [15:0] speed_i, rnd;
  logic engine_run_i, password_ok_i, key_enter_i, key_up_i, key_down_i, key_back_i;
  logic key_menu_i, fwd_drive_o, rev_drive_o, overspeed_override_warning_o;
  logic [2:0] ui_state_o;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  int mismatches, num_checks, cycles;

  cfs_feed_seq #(.HOLD_CYC(HOLD), .MS_CYC(4)) u_dut (.clk_i, .rst_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .speed_i, .engine_run_i, .password_ok_i, .key_enter_i, .key_up_i,
    .key_down_i, .key_back_i, .key_menu_i, .fwd_drive_o, .rev_drive_o, .ui_state_o,
    .overspeed_override_warning_o);
  cfs_operator_model #(.HOLD_CYC(HOLD)) u_op (.clk_i, .speed_o(speed_i),
    .engine_run_o(engine_run_i), .password_ok_o(password_ok_i), .key_enter_o(key_enter_i),
    .key_up_o(key_up_i), .key_down_o(key_down_i), .key_back_o(key_back_i),
    .key_menu_o(key_menu_i));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    num_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Sampled at the falling edge, where registered answers have settled
  always @(negedge clk_i)
    if (((s_axi_rvalid_o & s_axi_rready_i) | (s_axi_bvalid_o & s_axi_bready_i)) === 1'b1)
    begin
      e = exp_q.pop_front();
      check({s_axi_rvalid_o ? s_axi_rresp_o : s_axi_bresp_o, s_axi_rdata_o & e[65:34]}, e[33:0]);
    end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw, w, b;
    exp_q.push_back({32'h0, resp, 32'h0});
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do
    begin
      @(negedge clk_i);
      aw = s_axi_awvalid_i & s_axi_awready_o;
      w = s_axi_wvalid_i & s_axi_wready_o;
      b = s_axi_bvalid_o & s_axi_bready_i;
      @(posedge clk_i);
      if (aw)
        s_axi_awvalid_i <= 1'b0;
      if (w)
        s_axi_wvalid_i <= 1'b0;
      if (b)
        s_axi_bready_i <= 1'b0;
    end
    while (b !== 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] resp,
    input logic [31:0] d);
    logic ar, r;
    exp_q.push_back({m, resp, d});
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do
    begin
      @(negedge clk_i);
      ar = s_axi_arvalid_i & s_axi_arready_o;
      r = s_axi_rvalid_o & s_axi_rready_i;
      @(posedge clk_i);
      if (ar)
        s_axi_arvalid_i <= 1'b0;
      if (r)
        s_axi_rready_i <= 1'b0;
    end
    while (r !== 1'b1);
  endtask : rd

  // Status word: ui in [6:4], warning [2], reverse [1], forward [0]
  task automatic st(input logic [2:0] ui, input logic w, input logic r, input logic f);
    rd(cfs_pkg::OFS_STAT, 32'h77, 2'h0, {25'h0, ui, 1'b0, w, r, f});
  endtask : st

  initial
  begin
    rst_i = 1'b1;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hf;
    rnd = 16'h90bb;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cfs_pkg::OFS_CTRL, 32'h3, 2'h0, 32'h1);
    rd(cfs_pkg::OFS_FWD, 32'hffff, 2'h0, 32'h898);
    rd(cfs_pkg::OFS_REV, 32'hffff, 2'h0, 32'h708);
    rd(cfs_pkg::OFS_PULSE, 32'hffff, 2'h0, 32'h32);
    rd(8'h18, 32'hffffffff, 2'h2, 32'h0);
    wr(8'h1c, 32'h1, 2'h2);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test reset done");
    rnd = lfsr(rnd);
    u_op.set_speed(16'h898 + {8'h0, rnd[7:0]}, 1'b1);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    u_op.set_speed(16'h708, 1'b1);
    st(3'h0, 1'b0, 1'b1, 1'b0);
    repeat (185) @(posedge clk_i);
    st(3'h0, 1'b0, 1'b1, 1'b0);
    repeat (20) @(posedge clk_i);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    u_op.set_speed(16'h898, 1'b1);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    wr(cfs_pkg::OFS_CTRL, 32'h0, 2'h0);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test exclusive done");
    wr(cfs_pkg::OFS_PULSE, 32'h2, 2'h0);
    wr(cfs_pkg::OFS_CTRL, 32'h3, 2'h0);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    u_op.set_speed(16'h708, 1'b1);
    st(3'h0, 1'b0, 1'b1, 1'b1);
    repeat (10) @(posedge clk_i);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test overlap done");
    rnd = lfsr(rnd);
    u_op.set_speed({6'h0, rnd[9:0]}, 1'b1);
    u_op.hold(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    u_op.tap(1'b1, 1'b0);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    u_op.hold(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    u_op.hold(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    st(3'h2, 1'b0, 1'b0, 1'b0);
    u_op.hold(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    st(3'h3, 1'b0, 1'b0, 1'b1);
    u_op.hold(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    st(3'h4, 1'b0, 1'b1, 1'b1);
    wr(cfs_pkg::OFS_CTRL, 32'h1, 2'h0);
    u_op.hold(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    st(3'h4, 1'b0, 1'b1, 1'b0);
    u_op.hold(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    st(3'h2, 1'b0, 1'b0, 1'b0);
    u_op.hold(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    u_op.set_speed(16'h708, 1'b1);
    u_op.hold(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    st(3'h1, 1'b1, 1'b0, 1'b0);
    wr(cfs_pkg::OFS_STAT, 32'h4, 2'h0);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    u_op.tap(1'b0, 1'b1);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test override done");
    end_of_test();
  end
endmodule : cfs_feed_seq_bench

// ==== verif/cfs_operator_model.sv ====
// Engine speed source and operator keypad model.
// Assumes the sequencer clock; every move follows a rising edge.
module cfs_operator_model #(
  parameter int unsigned HOLD_CYC = 20
) (
  input wire logic clk_i,
  output logic [15:0] speed_o,
  output logic engine_run_o,
  output logic password_ok_o,
  output logic key_enter_o,
  output logic key_up_o,
  output logic key_down_o,
  output logic key_back_o,
  output logic key_menu_o
);
  initial
  begin
    {speed_o, engine_run_o, password_ok_o, key_enter_o} = '0;
    {key_up_o, key_down_o, key_back_o, key_menu_o} = '0;
  end
  task automatic set_speed(input logic [15:0] s, input logic run);
    @(posedge clk_i);
    speed_o <= s;
    engine_run_o <= run;
  endtask : set_speed
  // One-cycle pulses; the sequencer samples them on a single edge
  task automatic tap(input logic pw, input logic menu);
    @(posedge clk_i);
    password_ok_o <= pw;
    key_menu_o <= menu;
    @(posedge clk_i);
    password_ok_o <= 1'b0;
    key_menu_o <= 1'b0;
  endtask : tap
  // Arrow goes down a cycle before enter; a short hold lets go early
  task automatic hold(input logic up, input logic dn, input logic ent, input logic bk,
    input logic full);
    @(posedge clk_i);
    key_up_o <= up;
    key_down_o <= dn;
    key_back_o <= bk;
    @(posedge clk_i);
    key_enter_o <= ent;
    repeat (full ? HOLD_CYC + 8 : HOLD_CYC / 2) @(posedge clk_i);
    {key_up_o, key_down_o, key_back_o, key_enter_o} <= '0;
    repeat (2) @(posedge clk_i);
  endtask : hold
endmodule : cfs_operator_model
